// >>> src/dag_pkg.sv
package dag_pkg;
    localparam int ADDR_W      = 14;  // address width of both memory spaces
    localparam int DATA_W      = 16;  // register width
    localparam int PM_WORD_W   = 24;  // program memory word width
    localparam int EXT_W       = 8;   // low byte carried by the extension register
    localparam int NUM_PTR     = 4;   // index, modify and length registers per generator
    localparam int SEL_W       = 2;   // selector width for one of four
    localparam int GEN_W       = 2;   // generator select width
    localparam logic [1:0] GEN_DATA_ONLY = 2'h0;
    localparam logic [1:0] GEN_DUAL      = 2'h1;
    localparam logic [1:0] GEN_SERIAL    = 2'h2;  // selects no generator: loads with it are ignored; serial uses GEN_DUAL
    localparam logic [1:0] KIND_I   = 2'h0;  // register kind: index
    localparam logic [1:0] KIND_M   = 2'h1;  // register kind: modify
    localparam logic [1:0] KIND_L   = 2'h2;  // register kind: length
    localparam logic [13:0] RST_PTR = 14'h0000;
    localparam logic [7:0]  RST_EXT = 8'h00;
endpackage : dag_pkg

// >>> src/dag_addr_gen.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - each generator holds four index pointers that it updates itself
// - an indirect access post-modifies its pointer by one of four modify registers
// - a nonzero length makes the post-modify wrap inside a circular buffer
// - first generator addresses data memory only, with optional bit reversal
// - second generator addresses program or data memory, no bit reversal
// - both generators work in the same cycle for dual operand fetch
// - circular addressing also serves serial port auto transfers
// - a register written to program memory takes its low byte from extension
// - data read from program memory loads its low byte into extension
module dag_addr_gen
    import dag_pkg::*;
(
    input  wire logic              i_clock,
    input  wire logic              i_rst,
    // register loads from the core
    input  wire logic              i_load,
    input  wire logic [GEN_W-1:0]  i_load_gen,
    input  wire logic [1:0]        i_load_kind,
    input  wire logic [SEL_W-1:0]  i_load_sel,
    input  wire logic [ADDR_W-1:0] i_load_data,
    // first generator access
    input  wire logic              i_dm_req,
    input  wire logic [SEL_W-1:0]  i_dm_isel,
    input  wire logic [SEL_W-1:0]  i_dm_msel,
    input  wire logic              i_dm_bitrev,
    // second generator access
    input  wire logic              i_pm_req,
    input  wire logic              i_pm_space_is_pm,
    input  wire logic [SEL_W-1:0]  i_pm_isel,
    input  wire logic [SEL_W-1:0]  i_pm_msel,
    // serial port auto-transfer uses the second generator when it is idle
    input  wire logic              i_sp_req,
    input  wire logic [SEL_W-1:0]  i_sp_isel,
    input  wire logic [SEL_W-1:0]  i_sp_msel,
    // program memory data transfers
    input  wire logic              i_pm_write,
    input  wire logic [DATA_W-1:0] i_pm_wr_reg,
    input  wire logic              i_pm_read,
    input  wire logic [PM_WORD_W-1:0] i_pm_rd_word,
    input  wire logic              i_ext_load,
    input  wire logic [EXT_W-1:0]  i_ext_data,
    output logic [ADDR_W-1:0]      o_dm_addr,
    output logic                   o_dm_addr_valid,
    output logic [ADDR_W-1:0]      o_dual_addr,
    output logic                   o_dual_addr_valid,
    output logic                   o_dual_is_pm,
    output logic                   o_sp_grant,
    output logic [PM_WORD_W-1:0]   o_progmem_data_bus,
    output logic [DATA_W-1:0]      o_datamem_data_bus,
    output logic [EXT_W-1:0]       o_pm_low_byte_ext
);
    typedef logic [ADDR_W-1:0] dag_addr_type;

    dag_addr_type idx_q [2][NUM_PTR];
    dag_addr_type mod_q [2][NUM_PTR];
    dag_addr_type len_q [2][NUM_PTR];
    dag_addr_type base_q [2][NUM_PTR];
    logic [EXT_W-1:0] ext_q;

    // post-modify with optional circular wrap; base tracks buffer start
    function automatic dag_addr_type next_ptr(dag_addr_type i, dag_addr_type m,
                                              dag_addr_type l, dag_addr_type b);
        logic [ADDR_W:0] sum;
        logic [ADDR_W:0] top;
        sum = {1'b0, i} + {m[ADDR_W-1], m};
        top = {1'b0, b} + {1'b0, l};
        if (l == '0) begin
            next_ptr = sum[ADDR_W-1:0];
        end else if (m[ADDR_W-1] == 1'b0 && sum >= top) begin
            next_ptr = ADDR_W'(sum - {1'b0, l});
        end else if (m[ADDR_W-1] == 1'b1 && (sum < {1'b0, b} || sum[ADDR_W])) begin
            next_ptr = ADDR_W'(sum + {1'b0, l});
        end else begin
            next_ptr = sum[ADDR_W-1:0];
        end
    endfunction : next_ptr

    function automatic dag_addr_type bit_rev(dag_addr_type a);
        for (int k = 0; k < ADDR_W; k++) begin
            bit_rev[k] = a[ADDR_W-1-k];
        end
    endfunction : bit_rev

    // serial port only steals the second generator when the core leaves it idle
    logic sp_go;
    logic [SEL_W-1:0] g2_isel;
    logic [SEL_W-1:0] g2_msel;
    assign sp_go   = i_sp_req && !i_pm_req;
    assign g2_isel = i_pm_req ? i_pm_isel : i_sp_isel;
    assign g2_msel = i_pm_req ? i_pm_msel : i_sp_msel;
    assign o_sp_grant = sp_go;

    // registers of both generators; loads and post-modifies in one process
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            for (int g = 0; g < 2; g++) begin
                for (int p = 0; p < NUM_PTR; p++) begin
                    idx_q[g][p]  <= RST_PTR;
                    mod_q[g][p]  <= RST_PTR;
                    len_q[g][p]  <= RST_PTR;
                    base_q[g][p] <= RST_PTR;
                end
            end
        end else begin
            if (i_load && i_load_gen <= GEN_DUAL) begin
                case (i_load_kind)
                    KIND_I: begin
                        idx_q[i_load_gen[0]][i_load_sel]  <= i_load_data;
                        base_q[i_load_gen[0]][i_load_sel] <= i_load_data;
                    end
                    KIND_M: mod_q[i_load_gen[0]][i_load_sel] <= i_load_data;
                    KIND_L: len_q[i_load_gen[0]][i_load_sel] <= i_load_data;
                    default: ;
                endcase
            end
            // both generators update in the same cycle
            if (i_dm_req) begin
                idx_q[0][i_dm_isel] <= next_ptr(idx_q[0][i_dm_isel], mod_q[0][i_dm_msel],
                    len_q[0][i_dm_isel], base_q[0][i_dm_isel]);
            end
            if (i_pm_req || sp_go) begin
                idx_q[1][g2_isel] <= next_ptr(idx_q[1][g2_isel], mod_q[1][g2_msel],
                    len_q[1][g2_isel], base_q[1][g2_isel]);
            end
        end
    end

    // registered addresses, taken before the post-modify
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_dm_addr         <= RST_PTR;
            o_dm_addr_valid   <= 1'b0;
            o_dual_addr       <= RST_PTR;
            o_dual_addr_valid <= 1'b0;
            o_dual_is_pm      <= 1'b0;
        end else begin
            o_dm_addr_valid <= i_dm_req;
            if (i_dm_req) begin
                o_dm_addr <= i_dm_bitrev ? bit_rev(idx_q[0][i_dm_isel])
                                         : idx_q[0][i_dm_isel];
            end
            o_dual_addr_valid <= i_pm_req || sp_go;
            if (i_pm_req || sp_go) begin
                o_dual_addr  <= idx_q[1][g2_isel];
                o_dual_is_pm <= i_pm_req && i_pm_space_is_pm;
            end
        end
    end

    // extension register: a data read wins over a direct load
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ext_q <= RST_EXT;
        end else if (i_pm_read) begin
            ext_q <= i_pm_rd_word[EXT_W-1:0];
        end else if (i_ext_load) begin
            ext_q <= i_ext_data;
        end
    end
    assign o_pm_low_byte_ext = ext_q;

    // program data path words
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_progmem_data_bus <= '0;
            o_datamem_data_bus <= '0;
        end else begin
            if (i_pm_write) begin
                o_progmem_data_bus <= {i_pm_wr_reg, ext_q};
            end
            if (i_pm_read) begin
                o_datamem_data_bus <= i_pm_rd_word[PM_WORD_W-1:EXT_W];
            end
        end
    end

    a_write_low_byte: assert property (@(posedge i_clock) disable iff (i_rst)
        i_pm_write |=> o_progmem_data_bus[EXT_W-1:0] == $past(ext_q))
        else $error("write low byte not from extension");

    a_read_ext_load: assert property (@(posedge i_clock) disable iff (i_rst)
        i_pm_read |=> ext_q == $past(i_pm_rd_word[EXT_W-1:0]))
        else $error("extension not loaded on read");

    a_read_high_word: assert property (@(posedge i_clock) disable iff (i_rst)
        i_pm_read |=> o_datamem_data_bus == $past(i_pm_rd_word[PM_WORD_W-1:EXT_W]))
        else $error("upper sixteen bits misrouted");

    a_linear_update: assert property (@(posedge i_clock) disable iff (i_rst)
        i_dm_req && !i_load && len_q[0][i_dm_isel] == '0 |=>
        idx_q[0][$past(i_dm_isel)] == dag_addr_type'($past(idx_q[0][i_dm_isel])
            + $past(mod_q[0][i_dm_msel])))
        else $error("linear post-modify wrong");

    a_dm_addr_out: assert property (@(posedge i_clock) disable iff (i_rst)
        i_dm_req && !i_dm_bitrev |=> o_dm_addr_valid && o_dm_addr == $past(idx_q[0][i_dm_isel]))
        else $error("data address not the pre-modify pointer");

    a_bitrev_out: assert property (@(posedge i_clock) disable iff (i_rst)
        i_dm_req && i_dm_bitrev |=> o_dm_addr == bit_rev($past(idx_q[0][i_dm_isel])))
        else $error("bit reversed address wrong");

    a_dual_concurrent: assert property (@(posedge i_clock) disable iff (i_rst)
        i_dm_req && i_pm_req |=> o_dm_addr_valid && o_dual_addr_valid)
        else $error("generators not concurrent");

    a_dual_space: assert property (@(posedge i_clock) disable iff (i_rst)
        i_pm_req |=> o_dual_is_pm == $past(i_pm_space_is_pm))
        else $error("second generator space wrong");

    a_serial_grant: assert property (@(posedge i_clock) disable iff (i_rst)
        o_sp_grant |-> !i_pm_req ##1 o_dual_addr_valid && !o_dual_is_pm)
        else $error("serial transfer not served");

    a_wrap_inside: assert property (@(posedge i_clock) disable iff (i_rst)
        i_dm_req && !i_load && len_q[0][i_dm_isel] != '0
        && idx_q[0][i_dm_isel] >= base_q[0][i_dm_isel]
        && idx_q[0][i_dm_isel] < base_q[0][i_dm_isel] + len_q[0][i_dm_isel]
        && !mod_q[0][i_dm_msel][ADDR_W-1] && mod_q[0][i_dm_msel] < len_q[0][i_dm_isel] |=>
        idx_q[0][$past(i_dm_isel)] >= base_q[0][$past(i_dm_isel)]
        && dag_addr_type'(idx_q[0][$past(i_dm_isel)] - base_q[0][$past(i_dm_isel)])
            < len_q[0][$past(i_dm_isel)])
        else $error("circular pointer left buffer");

    a_ptr_hold: assert property (@(posedge i_clock) disable iff (i_rst)
        !i_dm_req && !i_load |=> $stable(idx_q[0][0]))
        else $error("pointer changed without use");
endmodule : dag_addr_gen
`default_nettype wire

// >>> tb/dag_pm_model.sv
`timescale 1ns/1ps
`default_nettype none
// program memory stand-in for data reads
module dag_pm_model
    import dag_pkg::*;
(
    input  wire logic [ADDR_W-1:0] i_addr,
    output logic      [PM_WORD_W-1:0] o_word
);
    // word varies with address so a stale word shows up
    assign o_word = 24'h123456 ^ {10'h000, i_addr};
endmodule : dag_pm_model
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dag_pkg::*;
    logic              i_clock, i_rst, i_load, i_dm_req, i_dm_bitrev, i_pm_req, i_sp_req;
    logic              i_pm_space_is_pm, i_pm_write, i_pm_read, i_ext_load;
    logic [1:0]        i_load_gen, i_load_kind, i_load_sel, i_dm_isel, i_dm_msel;
    logic [1:0]        i_pm_isel, i_pm_msel, i_sp_isel, i_sp_msel;
    logic [ADDR_W-1:0] i_load_data, o_dm_addr, o_dual_addr, mem_addr;
    logic [DATA_W-1:0] i_pm_wr_reg, o_datamem_data_bus;
    logic [PM_WORD_W-1:0] i_pm_rd_word, o_progmem_data_bus;
    logic [EXT_W-1:0]  i_ext_data, o_pm_low_byte_ext;
    logic              o_dm_addr_valid, o_dual_addr_valid, o_dual_is_pm, o_sp_grant;
    int                fails, n_checks;

    dag_addr_gen i_dut (
        .i_clock            (i_clock),
        .i_rst              (i_rst),
        .i_load             (i_load),
        .i_load_gen         (i_load_gen),
        .i_load_kind        (i_load_kind),
        .i_load_sel         (i_load_sel),
        .i_load_data        (i_load_data),
        .i_dm_req           (i_dm_req),
        .i_dm_isel          (i_dm_isel),
        .i_dm_msel          (i_dm_msel),
        .i_dm_bitrev        (i_dm_bitrev),
        .i_pm_req           (i_pm_req),
        .i_pm_space_is_pm   (i_pm_space_is_pm),
        .i_pm_isel          (i_pm_isel),
        .i_pm_msel          (i_pm_msel),
        .i_sp_req           (i_sp_req),
        .i_sp_isel          (i_sp_isel),
        .i_sp_msel          (i_sp_msel),
        .i_pm_write         (i_pm_write),
        .i_pm_wr_reg        (i_pm_wr_reg),
        .i_pm_read          (i_pm_read),
        .i_pm_rd_word       (i_pm_rd_word),
        .i_ext_load         (i_ext_load),
        .i_ext_data         (i_ext_data),
        .o_dm_addr          (o_dm_addr),
        .o_dm_addr_valid    (o_dm_addr_valid),
        .o_dual_addr        (o_dual_addr),
        .o_dual_addr_valid  (o_dual_addr_valid),
        .o_dual_is_pm       (o_dual_is_pm),
        .o_sp_grant         (o_sp_grant),
        .o_progmem_data_bus (o_progmem_data_bus),
        .o_datamem_data_bus (o_datamem_data_bus),
        .o_pm_low_byte_ext  (o_pm_low_byte_ext)
    );
    dag_pm_model i_pm_model (.i_addr(mem_addr), .o_word(i_pm_rd_word));

    // free running clock
    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end

    // step to just after the next rising edge
    task automatic cyc();
        @(posedge i_clock);
        #1;
    endtask : cyc

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // register load with an idle cycle after it
    task automatic ld(input logic [1:0] gen, kind, sel, input logic [13:0] val);
        {i_load, i_load_gen, i_load_kind, i_load_sel, i_load_data} = {1'b1, gen, kind, sel, val};
        cyc();
        i_load = 1'b0;
        cyc();
    endtask : ld

    task automatic finish_test();
        if (fails == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // linear post-modify back to back, then bit reversal
    task automatic t_linear();
        ld(2'h0, KIND_I, 2'h0, 14'h0010);
        ld(2'h0, KIND_M, 2'h1, 14'h0003);
        ld(2'h0, KIND_L, 2'h0, 14'h0000);
        {i_dm_req, i_dm_isel, i_dm_msel, i_dm_bitrev} = {1'b1, 2'h0, 2'h1, 1'b0};
        cyc();
        chk(24'(o_dm_addr), 24'h10);
        chk(24'(o_dm_addr_valid), 24'h1);
        cyc();
        chk(24'(o_dm_addr), 24'h13);
        i_dm_bitrev = 1'b1;
        cyc();
        chk(24'(o_dm_addr), 24'h1a00);
        {i_dm_req, i_dm_bitrev} = 2'b00;
        cyc();
        chk(24'(o_dm_addr_valid), 24'h0);
    endtask : t_linear

    // circular wrap both ways, with a concurrent data fetch
    task automatic t_circ();
        ld(2'h1, KIND_I, 2'h1, 14'h0020);
        ld(2'h1, KIND_M, 2'h0, 14'h0003);
        ld(2'h1, KIND_L, 2'h1, 14'h0004);
        {i_pm_req, i_pm_space_is_pm, i_pm_isel, i_pm_msel} = {1'b1, 1'b1, 2'h1, 2'h0};
        cyc();
        chk(24'(o_dual_addr), 24'h20);
        chk(24'(o_dual_is_pm), 24'h1);
        cyc();
        chk(24'(o_dual_addr), 24'h23);
        {i_pm_space_is_pm, i_dm_req} = 2'b01;
        cyc();
        chk(24'(o_dual_addr), 24'h22);
        chk(24'(o_dual_is_pm), 24'h0);
        chk(24'(o_dm_addr), 24'h19);
        chk(24'(o_dual_addr_valid), 24'h1);
        i_dm_req = 1'b0;
        ld(2'h1, KIND_I, 2'h2, 14'h0030);
        ld(2'h1, KIND_M, 2'h2, 14'h3fff);
        ld(2'h1, KIND_L, 2'h2, 14'h0002);
        {i_pm_isel, i_pm_msel} = 4'ha;
        cyc();
        chk(24'(o_dual_addr), 24'h30);
        cyc();
        chk(24'(o_dual_addr), 24'h31);
        i_pm_req = 1'b0;
        cyc();
    endtask : t_circ

    // serial port waits while the core holds the second generator
    task automatic t_serial();
        ld(2'h1, KIND_I, 2'h3, 14'h0040);
        ld(2'h1, KIND_M, 2'h1, 14'h0001);
        {i_sp_req, i_sp_isel, i_sp_msel, i_pm_req, i_pm_space_is_pm} = {1'b1, 4'hd, 2'b11};
        #1;
        chk(24'(o_sp_grant), 24'h0);
        cyc();
        chk(24'(o_dual_addr), 24'h30);
        i_pm_req = 1'b0;
        #1;
        chk(24'(o_sp_grant), 24'h1);
        cyc();
        chk(24'(o_dual_addr), 24'h40);
        chk(24'(o_dual_is_pm), 24'h0);
        cyc();
        chk(24'(o_dual_addr), 24'h41);
        i_sp_req = 1'b0;
        cyc();
    endtask : t_serial

    // extension byte through writes and reads; a read beats a direct load
    task automatic t_pmdata();
        {i_ext_load, i_ext_data} = {1'b1, 8'h99};
        cyc();
        {i_ext_load, i_pm_write, i_pm_wr_reg} = {2'b01, 16'habcd};
        cyc();
        chk(o_progmem_data_bus, 24'habcd99);
        {i_pm_write, i_pm_read, mem_addr} = {2'b01, 14'h0000};
        cyc();
        chk(24'(o_datamem_data_bus), 24'h1234);
        chk(24'(o_pm_low_byte_ext), 24'h56);
        {i_pm_write, i_pm_read, i_pm_wr_reg} = {2'b10, 16'hbeef};
        cyc();
        chk(o_progmem_data_bus, 24'hbeef56);
        {i_pm_write, i_pm_read, i_ext_load, mem_addr} = {3'b011, 14'h0011};
        cyc();
        chk(24'(o_pm_low_byte_ext), 24'h47);
        {i_pm_read, i_ext_load} = 2'b00;
        cyc();
    endtask : t_pmdata

    // circular wrap on the first generator; a load with generator select 2 must be ignored
    task automatic t_dm_circ();
        ld(2'h0, KIND_I, 2'h1, 14'h0008);
        ld(2'h2, KIND_I, 2'h1, 14'h0100);
        ld(2'h0, KIND_M, 2'h2, 14'h0002);
        ld(2'h0, KIND_L, 2'h1, 14'h0003);
        {i_dm_req, i_dm_isel, i_dm_msel} = {1'b1, 2'h1, 2'h2};
        cyc();
        chk(24'(o_dm_addr), 24'h8);
        cyc();
        chk(24'(o_dm_addr), 24'ha);
        cyc();
        chk(24'(o_dm_addr), 24'h9);
        i_dm_req = 1'b0;
        cyc();
    endtask : t_dm_circ

    // main sequence
    initial begin
        {i_load, i_dm_req, i_dm_bitrev, i_pm_req, i_sp_req, i_pm_space_is_pm} = '0;
        {i_pm_write, i_pm_read, i_ext_load, i_load_gen, i_load_kind, i_load_sel} = '0;
        {i_dm_isel, i_dm_msel, i_pm_isel, i_pm_msel, i_sp_isel, i_sp_msel} = '0;
        {i_load_data, mem_addr, i_pm_wr_reg, i_ext_data} = '0;
        {fails, n_checks} = '0;
        i_rst = 1'b1;
        repeat (2) cyc();
        i_rst = 1'b0;
        chk(24'(o_pm_low_byte_ext), 24'h0);
        t_linear();
        t_circ();
        t_serial();
        t_pmdata();
        t_dm_circ();
        finish_test();
    end

    // the tests need well under a hundred cycles
    initial begin
        repeat (1000) @(posedge i_clock);
        fails++;
        finish_test();
    end
endmodule : testbench
`default_nettype wire
